//--- etr_map.vh
// register indices, field positions and reset values of the event readout
// assumes inclusion by bare name from the design files
`ifndef ETR_MAP_VH
`define ETR_MAP_VH

// register indices, byte address is four times the index
`define ETR_IDX_STATUS    8'h1E
`define ETR_IDX_DATA      8'h1F
`define ETR_IDX_CTRL      8'h20
`define ETR_IDX_INT_STS   8'h21
`define ETR_IDX_INT_MASK  8'h22

// control register fields
`define ETR_CTRL_RISE     7:0
`define ETR_CTRL_FALL     15:8
`define ETR_CTRL_RST      16'h0000

// interrupt status and mask fields
`define ETR_INT_CAPT      0
`define ETR_INT_DROP      1
`define ETR_INT_RST       2'h0

// queue geometry
`define ETR_QPTR_W        3
`define ETR_QDEPTH        4
`define ETR_ENTRY_W       88

// queue entry fields
`define ETR_E_NS          29:0
`define ETR_E_SEC         61:30
`define ETR_E_DET         69:62
`define ETR_E_DIR         77:70
`define ETR_E_MULT        78
`define ETR_E_NUM         81:79
`define ETR_E_RF          82
`define ETR_E_LEN         84:83
`define ETR_E_MISS        87:85

`define ETR_MISS_MAX      3'h7

`endif

//--- etr_edge.v
// edge detector for one event input with separate rise and fall enables
// assumes the input is already synchronous to pclk
`timescale 1ns/100ps
`default_nettype none

module etr_edge
(
    input  wire pclk,
    input  wire presetn,
    input  wire pin,
    input  wire rise_en,
    input  wire fall_en,
    output wire rise,
    output wire fall
);

    reg prev_r;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prev_r <= 1'b0;
        else
            prev_r <= pin;
    end

    assign rise = rise_en & pin & ~prev_r;
    assign fall = fall_en & ~pin & prev_r;

endmodule

`default_nettype wire

//--- etr_info.v
// status fields of a new capture: lowest input, its direction,
// multiple-capture flag and index of the highest changed word above the low nanoseconds word
// assumes det is nonzero whenever the result is used
`timescale 1ns/100ps
`default_nettype none

module etr_info
(
    input  wire [7:0]  det,
    input  wire [7:0]  dir,
    input  wire [29:0] ns,
    input  wire [31:0] sec,
    input  wire [29:0] last_ns,
    input  wire [31:0] last_sec,
    output reg  [2:0]  num,
    output wire        rf,
    output wire        mult,
    output reg  [1:0]  len
);

    integer i;

    always @*
    begin
        num = 3'h0;
        for (i = 7; i >= 0; i = i - 1)
            if (det[i])
                num = i[2:0];
    end

    assign rf = dir[num];
    // more than one bit set
    assign mult = |(det & (det - 8'h01));

    // highest word that differs, counted from the low nanoseconds word as 0
    always @*
    begin
        if (sec[31:16] != last_sec[31:16])
            len = 2'h3;
        else if (sec[15:0] != last_sec[15:0])
            len = 2'h2;
        else if (ns[29:16] != last_ns[29:16])
            len = 2'h1;
        else
            len = 2'h0;
    end

endmodule

`default_nettype wire

//--- etr_readout.v
// event timestamp capture queue with status and data readout over APB
// assumes event inputs and the time inputs are synchronous to pclk
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "etr_map.vh"

module etr_readout
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         irq,
    input  wire [7:0]  evt_in,
    input  wire [29:0] time_ns,
    input  wire [31:0] time_sec
);

    // readout steps, one-hot
    localparam [4:0] ST_EXT = 5'h01;
    localparam [4:0] ST_NSL = 5'h02;
    localparam [4:0] ST_NSH = 5'h04;
    localparam [4:0] ST_SL  = 5'h08;
    localparam [4:0] ST_SH  = 5'h10;

    reg  [15:0]             ctrl_r;
    reg  [1:0]              int_sts_r;
    reg  [1:0]              int_sts_nxt;
    reg  [1:0]              int_mask_r;
    reg  [1:0]              int_mask_nxt;
    reg  [`ETR_ENTRY_W-1:0] q_mem [0:`ETR_QDEPTH-1];
    reg  [`ETR_QPTR_W-1:0]  wr_ptr_r;
    reg  [`ETR_QPTR_W-1:0]  rd_ptr_r;
    reg  [`ETR_ENTRY_W-1:0] cur_r;
    reg                     cur_valid_r;
    reg  [4:0]              state_r;
    reg  [4:0]              state_nxt;
    reg  [2:0]              miss_r;
    reg  [29:0]             last_ns_r;
    reg  [31:0]             last_sec_r;
    reg  [15:0]             data_word;
    reg  [31:0]             rdata_nxt;
    reg                     mapped;

    wire [7:0]              rise_w;
    wire [7:0]              fall_w;
    wire [7:0]              det_w;
    wire [2:0]              num_w;
    wire                    rf_w;
    wire                    mult_w;
    wire [1:0]              len_w;
    wire [`ETR_ENTRY_W-1:0] new_entry;
    wire [`ETR_ENTRY_W-1:0] head;
    wire                    empty;
    wire                    full;
    wire                    any_w;
    wire                    push;
    wire                    drop;
    wire                    acc;
    wire                    rd;
    wire                    wr;
    wire [7:0]              idx;
    wire                    rd_sts;
    wire                    rd_data;
    wire                    rd_int;
    wire [15:0]             sts_word;
    wire [15:0]             ext_word;
    wire [29:0]             cur_ns;
    wire [31:0]             cur_sec;
    wire [7:0]              cur_det;
    wire [7:0]              cur_dir;
    wire                    in_page;
    wire                    hit_sts;
    wire                    hit_data;
    wire                    hit_ctrl;
    wire                    hit_int;
    wire                    hit_mask;

    genvar g;

    // one edge detector per event input
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_edge
            etr_edge u_edge
            (
                .pclk    (pclk),
                .presetn (presetn),
                .pin     (evt_in[g]),
                .rise_en (ctrl_r[g]),
                .fall_en (ctrl_r[g+8]),
                .rise    (rise_w[g]),
                .fall    (fall_w[g])
            );
            // pair layout: seen on even bit, direction on odd bit
            assign ext_word[2*g]   = cur_det[g];
            assign ext_word[2*g+1] = cur_dir[g];
        end
    endgenerate

    // fields of the entry being read out
    assign cur_ns  = cur_r[`ETR_E_NS];
    assign cur_sec = cur_r[`ETR_E_SEC];
    assign cur_det = cur_r[`ETR_E_DET];
    assign cur_dir = cur_r[`ETR_E_DIR];

    assign det_w = rise_w | fall_w;
    assign any_w = |det_w;

    etr_info u_info
    (
        .det      (det_w),
        .dir      (rise_w),
        .ns       (time_ns),
        .sec      (time_sec),
        .last_ns  (last_ns_r),
        .last_sec (last_sec_r),
        .num      (num_w),
        .rf       (rf_w),
        .mult     (mult_w),
        .len      (len_w)
    );

    // entry layout follows the field map of the header
    assign new_entry = {miss_r, len_w, rf_w, num_w, mult_w,
                        rise_w, det_w, time_sec, time_ns};

    // queue pointers carry one wrap bit
    assign empty = (wr_ptr_r == rd_ptr_r);
    assign full  = ((wr_ptr_r ^ rd_ptr_r) == 3'h4);
    assign push  = any_w & ~full;
    assign drop  = any_w & full;
    assign head  = q_mem[rd_ptr_r[1:0]];

    // bus decode, one wait state before pready
    assign acc     = psel & penable & ~pready;
    assign rd      = acc & ~pwrite;
    assign wr      = acc & pwrite;
    assign idx      = paddr[9:2];
    assign in_page  = (paddr[11:10] == 2'h0);
    assign hit_sts  = in_page & (idx == `ETR_IDX_STATUS);
    assign hit_data = in_page & (idx == `ETR_IDX_DATA);
    assign hit_ctrl = in_page & (idx == `ETR_IDX_CTRL);
    assign hit_int  = in_page & (idx == `ETR_IDX_INT_STS);
    assign hit_mask = in_page & (idx == `ETR_IDX_INT_MASK);
    assign rd_sts   = rd & hit_sts;
    assign rd_data  = rd & hit_data;
    assign rd_int   = rd & hit_int;

    // status of the head entry, zero when nothing waits
    assign sts_word = empty ? 16'h0000 :
                      {5'h00, head[`ETR_E_MISS], head[`ETR_E_LEN],
                       head[`ETR_E_RF], head[`ETR_E_NUM],
                       head[`ETR_E_MULT], 1'b1};

    always @*
    begin
        mapped = hit_sts | hit_data | hit_ctrl | hit_int | hit_mask;
    end

    // data word of the current entry and the step that follows it
    always @*
    begin
        data_word = 16'h0000;
        state_nxt = state_r;
        case (state_r)
            ST_EXT:
            begin
                data_word = ext_word;
                state_nxt = ST_NSL;
            end
            ST_NSL:
            begin
                data_word = cur_ns[15:0];
                state_nxt = ST_NSH;
            end
            ST_NSH:
            begin
                data_word = {2'h0, cur_ns[29:16]};
                state_nxt = ST_SL;
            end
            ST_SL:
            begin
                data_word = cur_sec[15:0];
                state_nxt = ST_SH;
            end
            ST_SH:
            begin
                data_word = cur_sec[31:16];
                state_nxt = ST_NSL;
            end
            default:
            begin
                data_word = 16'h0000;
                state_nxt = ST_NSL;
            end
        endcase
        if (!cur_valid_r)
            data_word = 16'h0000;
    end

    always @*
    begin
        rdata_nxt = 32'h0000_0000;
        if (paddr[11:10] == 2'h0)
        begin
            case (idx)
                `ETR_IDX_STATUS:   rdata_nxt = {16'h0000, sts_word};
                `ETR_IDX_DATA:     rdata_nxt = {16'h0000, data_word};
                `ETR_IDX_CTRL:     rdata_nxt = {16'h0000, ctrl_r};
                `ETR_IDX_INT_STS:  rdata_nxt = {30'h0, int_sts_r};
                `ETR_IDX_INT_MASK: rdata_nxt = {30'h0, int_mask_r};
                default:           rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // a new event wins over the clear by read
    always @*
    begin
        int_sts_nxt = rd_int ? 2'h0 : int_sts_r;
        int_sts_nxt[`ETR_INT_CAPT] = int_sts_nxt[`ETR_INT_CAPT] | push;
        int_sts_nxt[`ETR_INT_DROP] = int_sts_nxt[`ETR_INT_DROP] | drop;
        int_mask_nxt = int_mask_r;
        if (wr && hit_mask)
            int_mask_nxt = pwdata[1:0];
    end

    // bus answers and registers, every output straight from a flop
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            irq        <= 1'b0;
            ctrl_r     <= `ETR_CTRL_RST;
            int_sts_r  <= `ETR_INT_RST;
            int_mask_r <= `ETR_INT_RST;
        end
        else
        begin
            pready     <= acc;
            pslverr    <= acc & ~mapped;
            prdata     <= rd ? rdata_nxt : 32'h0000_0000;
            int_sts_r  <= int_sts_nxt;
            int_mask_r <= int_mask_nxt;
            irq        <= |(int_sts_nxt & int_mask_nxt);
            if (wr && hit_ctrl)
                ctrl_r <= pwdata[15:0];
        end
    end

    // queue storage, no reset needed on the data words
    always @(posedge pclk)
    begin
        if (push)
            q_mem[wr_ptr_r[1:0]] <= new_entry;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_r   <= 3'h0;
            miss_r     <= 3'h0;
            last_ns_r  <= 30'h0;
            last_sec_r <= 32'h0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r   <= wr_ptr_r + 3'h1;
                miss_r     <= 3'h0;
                last_ns_r  <= time_ns;
                last_sec_r <= time_sec;
            end
            else if (drop && (miss_r != `ETR_MISS_MAX))
                miss_r <= miss_r + 3'h1;
        end
    end

    // status read moves the head into the readout slot
    // a status read on an empty queue also clears the slot,
    // so stale time never reads back as valid
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_ptr_r    <= 3'h0;
            cur_r       <= {`ETR_ENTRY_W{1'b0}};
            cur_valid_r <= 1'b0;
            state_r     <= ST_NSL;
        end
        else if (rd_sts)
        begin
            if (!empty)
            begin
                rd_ptr_r    <= rd_ptr_r + 3'h1;
                cur_r       <= head;
                cur_valid_r <= 1'b1;
                state_r     <= head[`ETR_E_MULT] ? ST_EXT :
                               ST_NSL;
            end
            else
            begin
                cur_r       <= {`ETR_ENTRY_W{1'b0}};
                cur_valid_r <= 1'b0;
                state_r     <= ST_NSL;
            end
        end
        // only data reads step the sequence
        else if (rd_data)
            state_r <= state_nxt;
    end

endmodule

`default_nettype wire

//--- etr_readout_chk.sv
// port assertions for the event readout block
// assumes binding onto etr_readout, single clock domain
`timescale 1ns/100ps
`default_nettype none
module etr_readout_chk
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_st;
    assign rd_st = pready && !pwrite && paddr == 12'h078;
    chk_ready_after_take: assert property
        (psel && penable && !pready |=> pready) else $error("no answer");
    chk_ready_one_pulse: assert property
        (pready |=> !pready) else $error("ready too long");
    chk_ready_has_cause: assert property
        (pready |-> $past(psel && penable)) else $error("stray ready");
    chk_rdata_idle_zero: assert property
        (!pready |-> prdata == 32'h0) else $error("idle data");
    chk_err_with_ready: assert property
        (pslverr |-> pready) else $error("stray error");
    chk_upper_half_zero: assert property
        (pready |-> prdata[31:16] == 16'h0) else $error("upper half");
    chk_status_word_form: assert property
        (rd_st |-> prdata[15:11] == 5'h0 && (prdata == 32'h0 || prdata[0]))
        else $error("status form");
    chk_write_no_data: assert property
        (pready && pwrite |-> prdata == 32'h0) else $error("write data");
    chk_unmapped_err: assert property
        (pready && !(paddr inside {12'h078, 12'h07C, 12'h080, 12'h084,
        12'h088}) |-> pslverr) else $error("no error");
    cov_multi: cover property (rd_st && prdata[1]);
    cov_err: cover property (pslverr);
    cov_missed: cover property (rd_st && prdata[8]);
    cov_irq: cover property ($rose(irq));
endmodule
bind etr_readout etr_readout_chk u_chk
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq)
);
`default_nettype wire

//--- etr_evt_src.sv
// event source and time base standing beside the readout block
// assumes the bench sets pattern and time together
`timescale 1ns/100ps
`default_nettype none
module etr_evt_src
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  pat,
    input  wire logic [29:0] ns_set,
    input  wire logic [31:0] sec_set,
    output var  logic [7:0]  evt_in,
    output var  logic [29:0] time_ns,
    output var  logic [31:0] time_sec
);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt_in <= 8'h00;
            time_ns <= 30'h0;
            time_sec <= 32'h0;
        end
        else
        begin
            evt_in <= pat;
            time_ns <= ns_set;
            time_sec <= sec_set;
        end
    end
endmodule
`default_nettype wire

//--- etr_readout_tb.sv
// self-checking bench for the event readout block
// assumes etr_readout, etr_evt_src and the bound checker
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [7:0]  pat, evt_in;
    logic [29:0] ns_set, time_ns;
    logic [31:0] sec_set, time_sec;
    logic        e;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    etr_readout u_etr_readout
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .evt_in(evt_in),
        .time_ns(time_ns), .time_sec(time_sec)
    );
    etr_evt_src u_etr_evt_src
    (
        .pclk(pclk), .presetn(presetn), .pat(pat), .ns_set(ns_set),
        .sec_set(sec_set), .evt_in(evt_in), .time_ns(time_ns),
        .time_sec(time_sec)
    );
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x)
        begin
            $display("wrong value at %0t: got %h exp %h", $time, g, x);
            fail_count++;
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(d, x);
    endtask
    task automatic ev(input logic [7:0] p, input logic [29:0] n,
                      input logic [31:0] s);
        @(posedge pclk);
        pat <= p;
        ns_set <= n;
        sec_set <= s;
        repeat (5) @(posedge pclk);
    endtask
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 12'h000;
        pwdata = 32'h0;
        pat = 8'h00;
        ns_set = 30'h0;
        sec_set = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h078, 32'h0);
        rd(12'h07C, 32'h0);
        xfer(1'b1, 12'h080, 32'h0000FFFF);
        xfer(1'b1, 12'h088, 32'h00000001);
        ev(8'h04, 30'h2ABCD123, 32'h12345678);
        chk({31'h0, irq}, 32'h1);
        rd(12'h078, 32'h000000E9);
        rd(12'h07C, 32'h0000D123);
        rd(12'h07C, 32'h00002ABC);
        rd(12'h07C, 32'h00005678);
        rd(12'h07C, 32'h00001234);
        rd(12'h07C, 32'h0000D123);
        rd(12'h084, 32'h00000001);
        chk({31'h0, irq}, 32'h0);
        ev(8'h83, 30'h2ABCFFFF, 32'h12345678);
        xfer(1'b1, 12'h088, 32'h00000000);
        chk({31'h0, irq}, 32'h0);
        ev(8'h03, 30'h3FFF1234, 32'h12345678);
        rd(12'h084, 32'h00000001);
        xfer(1'b1, 12'h088, 32'h00000001);
        chk({31'h0, irq}, 32'h0);
        rd(12'h078, 32'h00000023);
        rd(12'h07C, 32'h0000C01F);
        rd(12'h07C, 32'h0000FFFF);
        rd(12'h078, 32'h0000005D);
        rd(12'h07C, 32'h00001234);
        rd(12'h07C, 32'h00003FFF);
        rd(12'h078, 32'h0);
        rd(12'h07C, 32'h0);
        rd(12'h080, 32'h0000FFFF);
        xfer(1'b1, 12'h088, 32'h00000002);
        rd(12'h088, 32'h00000002);
        ev(8'h0B, 30'h3FFF1234, 32'h12345678);
        ev(8'h03, 30'h3FFF1234, 32'h12345678);
        ev(8'h0B, 30'h3FFF1234, 32'h12345678);
        ev(8'h03, 30'h3FFF1234, 32'h12345678);
        chk({31'h0, irq}, 32'h0);
        ev(8'h0B, 30'h3FFF1234, 32'h12345678);
        chk({31'h0, irq}, 32'h1);
        rd(12'h084, 32'h00000003);
        chk({31'h0, irq}, 32'h0);
        rd(12'h078, 32'h0000002D);
        ev(8'h03, 30'h3FFF1234, 32'h12345678);
        rd(12'h078, 32'h0000000D);
        rd(12'h078, 32'h0000002D);
        rd(12'h078, 32'h0000000D);
        rd(12'h078, 32'h0000010D);
        rd(12'h078, 32'h00000000);
        rd(12'h100, 32'h0);
        chk({31'h0, e}, 32'h1);
        summarize();
    end
endmodule
`default_nettype wire
